// >>> mws_flash_model.sv
// Purpose: Behavioural flash array that ends a started operation after run_len run cycles.
// Assumes: Same clock as the sequencer; a run_len of zero means the operation never ends.
// Notes:   Counting pauses while suspended, so a suspend really stretches the operation.
`timescale 1ns/1ps
`default_nettype none
module mws_flash_model (
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        flash_start,
   input  wire logic        flash_suspend,
   input  wire logic        flash_abort,
   input  wire logic [15:0] run_len,
   output logic             flash_op_done
);
   logic        running_reg;
   logic [15:0] count_reg;
   logic        hit;
   assign hit = (run_len != 16'h0000) && (count_reg + 16'h0001 == run_len);
   always_ff @(posedge clock) begin
      if (reset || flash_abort) begin
         running_reg   <= 1'b0;
         count_reg     <= 16'h0000;
         flash_op_done <= 1'b0;
      end else if (flash_start) begin
         running_reg   <= 1'b1;
         count_reg     <= 16'h0000;
         flash_op_done <= 1'b0;
      end else if (running_reg && !flash_suspend) begin
         count_reg     <= count_reg + 16'h0001;
         flash_op_done <= hit;
         running_reg   <= !hit;
      end else begin
         flash_op_done <= 1'b0;
      end
   end
endmodule : mws_flash_model
`default_nettype wire

// >>> mws_pkg.sv
// Purpose: Shared constants and types for the memory wait-state configuration block.
// Assumes: 40 MHz system clock, APB register access with one aligned 32-bit word per register.
// Notes:   Times are kept in their own units and turned into cycle counts here.
`default_nettype none
package mws_pkg;
   localparam int          ADDR_W        = 8;
   localparam logic [7:0]  OFS_SRAM_CFG  = 8'h00;
   localparam logic [7:0]  OFS_FLASH_CFG = 8'h04;
   localparam logic [7:0]  OFS_CMD       = 8'h08;
   localparam logic [7:0]  OFS_STATUS    = 8'h0c;
   localparam logic [7:0]  OFS_PAGE0     = 8'h10;
   localparam logic [7:0]  OFS_PAGE3     = 8'h1c;
   localparam int          PAGE_WORDS    = 4;
   localparam int          PAGE_BITS     = 128;
   // Field positions.
   localparam int          FC_PIPE_LSB   = 0;
   localparam int          FC_READ_LSB   = 4;
   localparam int          FC_WRITE_LSB  = 8;
   localparam int          CMD_OP_LSB    = 0;
   localparam int          CMD_START_BIT = 4;
   localparam int          CMD_SUSP_BIT  = 8;
   localparam int          CMD_RES_BIT   = 9;
   localparam int          ST_BUSY       = 0;
   localparam int          ST_DONE       = 1;
   localparam int          ST_TIMEOUT    = 2;
   localparam int          ST_SUSP       = 3;
   localparam int          ST_REFUSED    = 4;
   localparam int          ST_CFG_BAD    = 5;
   // Reset values and legal settings.
   localparam logic        SRAM_WAIT_RST = 1'b0;
   localparam logic [2:0]  READ_WAIT_RST = 3'h4;
   localparam logic [2:0]  READ_WAIT_MAX = 3'h4;
   localparam logic [1:0]  WRITE_WAIT_REQ = 2'h3;
   // Times as printed, then cycle counts.
   localparam int          CLK_KHZ       = 40000;
   localparam int          T_DWPROG_US   = 500;
   localparam int          T_PGPROG_US   = 500;
   localparam int          T_E16_MS      = 5000;
   localparam int          T_E64_MS      = 5000;
   localparam int          T_E128_MS     = 7500;
   localparam int          T_E256_MS     = 15000;
   localparam int          T_PSUSP_US    = 100;
   localparam int          T_ESUSP_MS    = 10;
   localparam int          C_DWPROG      = CLK_KHZ * T_DWPROG_US / 1000;
   localparam int          C_PGPROG      = CLK_KHZ * T_PGPROG_US / 1000;
   localparam int          C_E16         = CLK_KHZ * T_E16_MS;
   localparam int          C_E64         = CLK_KHZ * T_E64_MS;
   localparam int          C_E128        = CLK_KHZ * T_E128_MS;
   localparam int          C_E256        = CLK_KHZ * T_E256_MS;
   localparam int          C_PSUSP       = (CLK_KHZ * T_PSUSP_US + 999) / 1000;
   localparam int          C_ESUSP       = CLK_KHZ * T_ESUSP_MS;

   typedef enum logic [2:0] {
      OP_DWORD = 3'b000,
      OP_PAGE  = 3'b001,
      OP_E16   = 3'b010,
      OP_E64   = 3'b011,
      OP_E128  = 3'b100,
      OP_E256  = 3'b101
   } mws_op_e;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_RUN  = 2'b01,
      S_SUSP = 2'b10
   } mws_state_e;

   typedef struct packed {
      logic [1:0] write_wait;
      logic [2:0] read_wait;
      logic [2:0] pipe;
   } mws_flash_cfg_s;

   typedef struct packed {
      mws_op_e                op;
      logic [PAGE_BITS-1:0]   page;
   } mws_flash_op_s;
endpackage : mws_pkg
`default_nettype wire

// >>> mws_top.sv
// Functional notes
// - Static RAM extra wait clears at reset.
// - Program page is four 32-bit words.
// - Double word program ends within 500 us.
// - 16 KB erase ends within 5000 ms.
// - 256 KB erase ends within 15000 ms.
// - 128 KB erase ends within 7500 ms.
//
// Purpose: APB-programmed wait states for RAM and flash, and flash operation sequencing.
// Assumes: flash_op_done comes from logic on the same clock.
// Notes:   An operation that overruns its limit is aborted rather than left hanging.
`timescale 1ns/1ps
`default_nettype none
module mws_top #(
   parameter int LIM_DWPROG = mws_pkg::C_DWPROG,
   parameter int LIM_PGPROG = mws_pkg::C_PGPROG,
   parameter int LIM_E16    = mws_pkg::C_E16,
   parameter int LIM_E64    = mws_pkg::C_E64,
   parameter int LIM_E128   = mws_pkg::C_E128,
   parameter int LIM_E256   = mws_pkg::C_E256,
   parameter int MIN_PSUSP  = mws_pkg::C_PSUSP,
   parameter int MIN_ESUSP  = mws_pkg::C_ESUSP
) (
   input  wire logic                    clock,
   input  wire logic                    reset,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [mws_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    sram_req,
   output logic                         sram_ack,
   input  wire logic                    flash_req,
   input  wire logic                    flash_we,
   output logic                         flash_ack,
   output mws_pkg::mws_flash_cfg_s      flash_bus_iface_cfg,
   output mws_pkg::mws_flash_op_s       flash_op,
   output logic                         flash_start,
   output logic                         flash_suspend,
   output logic                         flash_abort,
   input  wire logic                    flash_op_done
);
   logic                         sram_extra_wait_sel_reg;
   mws_pkg::mws_flash_cfg_s      fcfg_reg;
   mws_pkg::mws_flash_op_s       op_reg;
   logic [31:0]                  page_reg [mws_pkg::PAGE_WORDS];
   mws_pkg::mws_state_e          st_reg;
   logic [31:0]                  run_cnt_reg, res_cnt_reg, prdata_reg;
   logic                         resumed_reg, done_reg, timeout_reg, refused_reg;
   logic                         start_reg, abort_reg;
   logic                         wr, rd_setup, mapped, is_prog;
   logic                         cmd_start, cmd_susp, cmd_res, susp_ok;
   logic                         done_evt, tmo_evt, refuse_evt, cfg_bad;
   logic [31:0]                  op_limit, susp_min, status;
   logic [2:0]                   flash_waits;
   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr == mws_pkg::OFS_SRAM_CFG) || (paddr == mws_pkg::OFS_FLASH_CFG)
                  || (paddr == mws_pkg::OFS_CMD) || (paddr == mws_pkg::OFS_STATUS)
                  || ((paddr >= mws_pkg::OFS_PAGE0) && (paddr <= mws_pkg::OFS_PAGE3)
                      && (paddr[1:0] == 2'h0));
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign prdata   = prdata_reg;

   // Software-side setting errors are only reported, since the band choice is software's.
   assign cfg_bad = (fcfg_reg.pipe != fcfg_reg.read_wait)
                 || (fcfg_reg.write_wait != mws_pkg::WRITE_WAIT_REQ)
                 || (fcfg_reg.read_wait > mws_pkg::READ_WAIT_MAX);

   assign is_prog = (op_reg.op == mws_pkg::OP_DWORD) || (op_reg.op == mws_pkg::OP_PAGE);

   always_comb begin
      case (op_reg.op)
         mws_pkg::OP_DWORD: op_limit = 32'(LIM_DWPROG);
         mws_pkg::OP_PAGE:  op_limit = 32'(LIM_PGPROG);
         mws_pkg::OP_E16:   op_limit = 32'(LIM_E16);
         mws_pkg::OP_E64:   op_limit = 32'(LIM_E64);
         mws_pkg::OP_E128:  op_limit = 32'(LIM_E128);
         mws_pkg::OP_E256:  op_limit = 32'(LIM_E256);
         default:           op_limit = 32'(LIM_DWPROG);
      endcase
   end

   assign susp_min  = is_prog ? 32'(MIN_PSUSP) : 32'(MIN_ESUSP);
   assign susp_ok   = !resumed_reg || (res_cnt_reg >= susp_min);
   assign cmd_start = wr && (paddr == mws_pkg::OFS_CMD) && pwdata[mws_pkg::CMD_START_BIT];
   assign cmd_susp  = wr && (paddr == mws_pkg::OFS_CMD) && pwdata[mws_pkg::CMD_SUSP_BIT];
   assign cmd_res   = wr && (paddr == mws_pkg::OFS_CMD) && pwdata[mws_pkg::CMD_RES_BIT];
   assign done_evt  = (st_reg == mws_pkg::S_RUN) && flash_op_done;
   assign tmo_evt   = (st_reg == mws_pkg::S_RUN) && !flash_op_done
                   && (run_cnt_reg >= op_limit - 32'h1);
   assign refuse_evt = cmd_susp && (st_reg == mws_pkg::S_RUN) && !susp_ok;

   always_comb begin
      status = '0;
      status[mws_pkg::ST_BUSY]    = (st_reg != mws_pkg::S_IDLE);
      status[mws_pkg::ST_DONE]    = done_reg;
      status[mws_pkg::ST_TIMEOUT] = timeout_reg;
      status[mws_pkg::ST_SUSP]    = (st_reg == mws_pkg::S_SUSP);
      status[mws_pkg::ST_REFUSED] = refused_reg;
      status[mws_pkg::ST_CFG_BAD] = cfg_bad;
   end

   // Configuration registers.
   always_ff @(posedge clock) begin
      if (reset) begin
         sram_extra_wait_sel_reg <= mws_pkg::SRAM_WAIT_RST;
         fcfg_reg.pipe       <= mws_pkg::READ_WAIT_RST;
         fcfg_reg.read_wait  <= mws_pkg::READ_WAIT_RST;
         fcfg_reg.write_wait <= mws_pkg::WRITE_WAIT_REQ;
      end else if (wr && (paddr == mws_pkg::OFS_SRAM_CFG)) begin
         sram_extra_wait_sel_reg <= pwdata[0];
      end else if (wr && (paddr == mws_pkg::OFS_FLASH_CFG)) begin
         fcfg_reg.pipe       <= pwdata[mws_pkg::FC_PIPE_LSB +: 3];
         fcfg_reg.read_wait  <= pwdata[mws_pkg::FC_READ_LSB +: 3];
         fcfg_reg.write_wait <= pwdata[mws_pkg::FC_WRITE_LSB +: 2];
      end
   end

   // Page buffer; a program captures all four words at once.
   always_ff @(posedge clock) begin
      for (int i = 0; i < mws_pkg::PAGE_WORDS; i++) begin
         if (reset) begin
            page_reg[i] <= 32'h0;
         end else if (wr && (paddr == mws_pkg::OFS_PAGE0 + 8'(4 * i))) begin
            page_reg[i] <= pwdata;
         end
      end
   end

   // Operation sequencer.
   always_ff @(posedge clock) begin
      if (reset) begin
         st_reg      <= mws_pkg::S_IDLE;
         op_reg      <= '0;
         run_cnt_reg <= 32'h0;
         start_reg   <= 1'b0;
         abort_reg   <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         abort_reg <= 1'b0;
         case (st_reg)
            mws_pkg::S_IDLE: begin
               if (cmd_start) begin
                  op_reg.op   <= mws_pkg::mws_op_e'(pwdata[mws_pkg::CMD_OP_LSB +: 3]);
                  op_reg.page <= {page_reg[3], page_reg[2], page_reg[1], page_reg[0]};
                  run_cnt_reg <= 32'h0;
                  start_reg   <= 1'b1;
                  st_reg      <= mws_pkg::S_RUN;
               end
            end
            mws_pkg::S_RUN: begin
               run_cnt_reg <= run_cnt_reg + 32'h1;
               if (done_evt) begin
                  st_reg <= mws_pkg::S_IDLE;
               end else if (tmo_evt) begin
                  abort_reg <= 1'b1;
                  st_reg    <= mws_pkg::S_IDLE;
               end else if (cmd_susp && susp_ok) begin
                  st_reg <= mws_pkg::S_SUSP;
               end
            end
            mws_pkg::S_SUSP: begin
               if (cmd_res) begin
                  st_reg <= mws_pkg::S_RUN;
               end
            end
            default: st_reg <= mws_pkg::S_IDLE;
         endcase
      end
   end
   // Time since the last resume; a start written while busy is ignored and must not reset it.
   always_ff @(posedge clock) begin
      if (reset || (cmd_start && (st_reg == mws_pkg::S_IDLE))) begin
         resumed_reg <= 1'b0;
         res_cnt_reg <= 32'h0;
      end else if ((st_reg == mws_pkg::S_SUSP) && cmd_res) begin
         resumed_reg <= 1'b1;
         res_cnt_reg <= 32'h0;
      end else if ((st_reg == mws_pkg::S_RUN) && (res_cnt_reg < susp_min)) begin
         res_cnt_reg <= res_cnt_reg + 32'h1;
      end
   end

   // Sticky status; a set in the same cycle as the clear wins.
   always_ff @(posedge clock) begin
      if (reset) begin
         done_reg    <= 1'b0;
         timeout_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else begin
         done_reg    <= done_evt || (done_reg && !(wr && (paddr == mws_pkg::OFS_STATUS)
                        && pwdata[mws_pkg::ST_DONE]));
         timeout_reg <= tmo_evt || (timeout_reg && !(wr && (paddr == mws_pkg::OFS_STATUS)
                        && pwdata[mws_pkg::ST_TIMEOUT]));
         refused_reg <= refuse_evt || (refused_reg && !(wr && (paddr == mws_pkg::OFS_STATUS)
                        && pwdata[mws_pkg::ST_REFUSED]));
      end
   end

   // Read data is fetched in the setup phase so it comes from a flip-flop.
   always_ff @(posedge clock) begin
      if (reset) begin
         prdata_reg <= 32'h0;
      end else if (rd_setup) begin
         prdata_reg <= 32'h0;
         case (paddr)
            mws_pkg::OFS_SRAM_CFG:  prdata_reg <= {31'h0, sram_extra_wait_sel_reg};
            mws_pkg::OFS_FLASH_CFG: prdata_reg <= {22'h0, fcfg_reg.write_wait, 1'b0,
                                                   fcfg_reg.read_wait, 1'b0, fcfg_reg.pipe};
            mws_pkg::OFS_CMD:       prdata_reg <= {29'h0, op_reg.op};
            mws_pkg::OFS_STATUS:    prdata_reg <= status;
            default: begin
               if ((paddr >= mws_pkg::OFS_PAGE0) && (paddr <= mws_pkg::OFS_PAGE3)) begin
                  prdata_reg <= page_reg[paddr[3:2]];
               end
            end
         endcase
      end
   end

   assign flash_waits = flash_we ? {1'b0, fcfg_reg.write_wait} : fcfg_reg.read_wait;

   mws_wait_stretch #(.W(1)) u_sram_wait (
      .clock (clock),
      .reset (reset),
      .req   (sram_req),
      .waits (sram_extra_wait_sel_reg),
      .ack   (sram_ack)
   );
   mws_wait_stretch #(.W(3)) u_flash_wait (
      .clock (clock),
      .reset (reset),
      .req   (flash_req),
      .waits (flash_waits),
      .ack   (flash_ack)
   );

   assign flash_bus_iface_cfg = fcfg_reg;
   assign flash_op            = op_reg;
   assign flash_start         = start_reg;
   assign flash_suspend       = (st_reg == mws_pkg::S_SUSP);
   assign flash_abort         = abort_reg;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   AST_SRAM_RST_ZERO: assert property ($fell(reset) |-> !sram_extra_wait_sel_reg)
      else $error("RAM wait field not zero after reset.");
   AST_SRAM_ONE_WAIT: assert property ($rose(sram_req) && sram_extra_wait_sel_reg
      |-> !sram_ack ##1 (sram_ack || !sram_req))
      else $error("RAM access not stretched by one cycle.");
   AST_FLASH_RD_WAIT: assert property (($rose(flash_req) && !flash_we
      && fcfg_reg.read_wait == 3'h2) |-> (!flash_ack)[*2] ##1 (flash_ack || !flash_req))
      else $error("Flash read not stretched by two cycles.");
   AST_PAGE_CAPTURE: assert property (cmd_start && st_reg == mws_pkg::S_IDLE
      |=> flash_op.page == {page_reg[3], page_reg[2], page_reg[1], page_reg[0]} && flash_start)
      else $error("Page not captured as four words.");
   AST_DWORD_LIMIT: assert property (st_reg == mws_pkg::S_RUN && !flash_op_done
      && op_reg.op == mws_pkg::OP_DWORD && run_cnt_reg == 32'(LIM_DWPROG) - 32'h1
      |=> st_reg == mws_pkg::S_IDLE && flash_abort && timeout_reg)
      else $error("Double word program not ended at its limit.");
   AST_E16_BOUND: assert property (st_reg == mws_pkg::S_RUN && op_reg.op == mws_pkg::OP_E16
      |-> run_cnt_reg < 32'(LIM_E16))
      else $error("16 KB erase ran past its limit.");
   AST_E256_BOUND: assert property (st_reg == mws_pkg::S_RUN && op_reg.op == mws_pkg::OP_E256
      |-> run_cnt_reg < 32'(LIM_E256))
      else $error("256 KB erase ran past its limit.");
   AST_E128_BOUND: assert property (st_reg == mws_pkg::S_RUN
      && op_reg.op == mws_pkg::OP_E128 |-> run_cnt_reg < 32'(LIM_E128))
      else $error("128 KB erase ran past its limit.");
   AST_PSUSP_SPACING: assert property (st_reg == mws_pkg::S_RUN && is_prog && cmd_susp
      && !flash_op_done && !tmo_evt && resumed_reg && res_cnt_reg < 32'(MIN_PSUSP)
      |=> !flash_suspend && refused_reg)
      else $error("Early program suspend was accepted.");
   AST_ESUSP_SPACING: assert property (st_reg == mws_pkg::S_RUN && !is_prog && cmd_susp
      && !flash_op_done && !tmo_evt && resumed_reg && res_cnt_reg < 32'(MIN_ESUSP)
      |=> !flash_suspend && refused_reg)
      else $error("Early erase suspend was accepted.");
   AST_CFG_FLAG: assert property (fcfg_reg.pipe != fcfg_reg.read_wait
      |-> status[mws_pkg::ST_CFG_BAD])
      else $error("Unequal pipelining and read wait not flagged.");
   COV_SRAM_WAIT: cover property (sram_req && sram_extra_wait_sel_reg ##1 sram_ack);
   COV_TIMEOUT:   cover property (tmo_evt);
   COV_SUSP_RES:  cover property (flash_suspend ##[1:20] cmd_res);
endmodule : mws_top
`default_nettype wire

// >>> mws_wait_stretch.sv
// Purpose: Stretches one memory access by a programmed number of wait cycles.
// Assumes: The requester holds req until ack.
// Notes:   Zero waits give ack in the cycle of the request.
`timescale 1ns/1ps
`default_nettype none
module mws_wait_stretch #(
   parameter int W = 3
) (
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         req,
   input  wire logic [W-1:0] waits,
   output logic              ack
);
   logic [W-1:0] cnt_reg;

   assign ack = req && (cnt_reg == waits);

   always_ff @(posedge clock) begin
      if (reset || !req || ack) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
      end
   end
endmodule : mws_wait_stretch
`default_nettype wire

// >>> test_memory_wait_state_config.sv
// Purpose: Self-checking bench for the memory wait-state and flash sequencing block.
// Assumes: Shortened limits; the flash model answers on the same clock.
// Notes:   Timing windows allow two cycles of slack either side for aborts and three late for done, as start-to-count alignment is internal.
`timescale 1ns/1ps
`default_nettype none
module test_memory_wait_state_config;
   logic        clock, reset, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        err, sram_req, sram_ack, flash_req, flash_we, flash_ack;
   logic        flash_start, flash_suspend, flash_abort, flash_op_done;
   logic [15:0] run_len;
   mws_pkg::mws_flash_cfg_s cfg_port;
   mws_pkg::mws_flash_op_s  flash_op;
   int errors, checks_done;
   localparam int LIM_PROG    = 50;
   localparam int LIM_E_SMALL = 200;
   localparam int LIM_E_MID   = 300;
   localparam int LIM_E_BIG   = 600;
   localparam int GAP_PROG    = 10;
   localparam int GAP_ERASE   = 40;
   int lim [6] = '{LIM_PROG, LIM_PROG, LIM_E_SMALL, LIM_E_SMALL, LIM_E_MID, LIM_E_BIG};
   mws_top #(.LIM_DWPROG(LIM_PROG), .LIM_PGPROG(LIM_PROG), .LIM_E16(LIM_E_SMALL),
      .LIM_E64(LIM_E_SMALL), .LIM_E128(LIM_E_MID), .LIM_E256(LIM_E_BIG), .MIN_PSUSP(GAP_PROG),
      .MIN_ESUSP(GAP_ERASE)) dut (.clock(clock), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sram_req(sram_req),
      .sram_ack(sram_ack), .flash_req(flash_req), .flash_we(flash_we), .flash_ack(flash_ack),
      .flash_bus_iface_cfg(cfg_port), .flash_op(flash_op), .flash_start(flash_start),
      .flash_suspend(flash_suspend), .flash_abort(flash_abort), .flash_op_done(flash_op_done));
   mws_flash_model partner (.clock(clock), .reset(reset), .flash_start(flash_start),
      .flash_suspend(flash_suspend), .flash_abort(flash_abort), .run_len(run_len),
      .flash_op_done(flash_op_done));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   function automatic logic [31:0] cfg_word(input int p, input int r, input int w);
      return (32'(w) << mws_pkg::FC_WRITE_LSB) | (32'(r) << mws_pkg::FC_READ_LSB) | 32'(p);
   endfunction : cfg_word
   function automatic logic [31:0] cfg_bad(input int p, input int r, input int w);
      return 32'((p != r) || (w != 3) || (r > 4));
   endfunction : cfg_bad
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic mem(input logic ram, input logic we, input int waits, input string what);
      int n;
      @(posedge clock);
      sram_req  <= ram;
      flash_req <= !ram;
      flash_we  <= we;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while ((ram ? sram_ack : flash_ack) !== 1'b1 && n < 20);
      sram_req  <= 1'b0;
      flash_req <= 1'b0;
      check(what, 32'(waits + 1), 32'(n));
   endtask : mem
   task automatic wait_end(output int n);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (flash_abort !== 1'b1 && flash_op_done !== 1'b1 && n < 2000);
   endtask : wait_end
   task automatic run_op(input int op, input int len);
      logic [127:0] page;
      int n;
      page = {$urandom, $urandom, $urandom, $urandom};
      for (int w = 0; w < 4; w++) apb(1'b1, 8'(mws_pkg::OFS_PAGE0 + 4 * w), page[32*w +: 32]);
      apb(1'b1, mws_pkg::OFS_STATUS, 32'h0000_0016);
      run_len <= 16'(len);
      apb(1'b1, mws_pkg::OFS_CMD, 32'(op) | 32'h0000_0010);
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (flash_start !== 1'b1 && n < 10);
      check("op_code", 32'(op), 32'(flash_op.op));
      for (int w = 0; w < 4; w++) begin
         check("page_word", page[32*w +: 32], flash_op.page[32*w +: 32]);
      end
      wait_end(n);
      if (len == 0) begin
         check("abort_time", 32'h1, 32'(n >= lim[op] - 2 && n <= lim[op] + 2));
      end else begin
         check("done_time", 32'h1, 32'(n >= len && n <= len + 3));
      end
      repeat (2) @(posedge clock);
      apb(1'b0, mws_pkg::OFS_STATUS, 32'h0);
      check("status", (len == 0) ? 32'h4 : 32'h2, rd & 32'h7);
      apb(1'b0, mws_pkg::OFS_CMD, 32'h0);
      check("cmd_read", 32'(op), rd);
   endtask : run_op
   task automatic susp(input int op, input int gap);
      int n;
      apb(1'b1, mws_pkg::OFS_STATUS, 32'h0000_0016);
      run_len <= 16'h0000;
      apb(1'b1, mws_pkg::OFS_CMD, 32'(op) | 32'h0000_0010);
      repeat (3) @(posedge clock);
      apb(1'b1, mws_pkg::OFS_CMD, 32'h0000_0100);
      @(posedge clock);
      check("suspended", 32'h1, 32'(flash_suspend));
      apb(1'b1, mws_pkg::OFS_CMD, 32'h0000_0200);
      @(posedge clock);
      check("resumed", 32'h0, 32'(flash_suspend));
      apb(1'b1, mws_pkg::OFS_CMD, 32'h0000_0100);
      @(posedge clock);
      check("early_suspend", 32'h0, 32'(flash_suspend));
      apb(1'b0, mws_pkg::OFS_STATUS, 32'h0);
      check("refused", 32'h1, 32'(rd[mws_pkg::ST_REFUSED]));
      repeat (gap + 2) @(posedge clock);
      apb(1'b1, mws_pkg::OFS_CMD, 32'h0000_0100);
      @(posedge clock);
      check("late_suspend", 32'h1, 32'(flash_suspend));
      apb(1'b1, mws_pkg::OFS_CMD, 32'h0000_0200);
      wait_end(n);
      check("abort", 32'h1, 32'(flash_abort));
   endtask : susp
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      int p, r, w;
      {reset, psel, penable, pwrite, sram_req, flash_req, flash_we} = 7'b1000000;
      {paddr, pwdata, run_len, errors, checks_done} = '0;
      void'($urandom(22041));
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      apb(1'b0, mws_pkg::OFS_SRAM_CFG, 32'h0);
      check("sram_cfg", 32'h0, rd);
      mem(1'b1, 1'b0, 0, "sram_wait0");
      apb(1'b0, mws_pkg::OFS_FLASH_CFG, 32'h0);
      check("flash_cfg", cfg_word(4, 4, 3), rd);
      apb(1'b0, 8'h40, 32'h0);
      check("unmapped_err", 32'h1, 32'(err));
      check("unmapped_data", 32'h0, rd);
      apb(1'b1, mws_pkg::OFS_SRAM_CFG, 32'h1);
      mem(1'b1, 1'b0, 1, "sram_wait1");
      $display("test reset and ram waits done");
      for (int b = 0; b < 5; b++) begin
         apb(1'b1, mws_pkg::OFS_FLASH_CFG, cfg_word(b, b, 3));
         apb(1'b0, mws_pkg::OFS_STATUS, 32'h0);
         check("cfg_bad_band", 32'h0, 32'(rd[mws_pkg::ST_CFG_BAD]));
         mem(1'b0, 1'b0, b, "flash_read");
         mem(1'b0, 1'b1, 3, "flash_write");
      end
      for (int k = 0; k < 8; k++) begin
         p = $urandom_range(0, 7);
         r = (k == 0) ? p : $urandom_range(0, 7);
         w = $urandom_range(0, 3);
         apb(1'b1, mws_pkg::OFS_FLASH_CFG, cfg_word(p, r, w));
         @(posedge clock);
         check("cfg_port", 32'({2'(w), 3'(r), 3'(p)}), 32'(cfg_port));
         apb(1'b0, mws_pkg::OFS_STATUS, 32'h0);
         check("cfg_bad", cfg_bad(p, r, w), 32'(rd[mws_pkg::ST_CFG_BAD]));
      end
      apb(1'b1, mws_pkg::OFS_FLASH_CFG, cfg_word(4, 4, 3));
      $display("test flash waits done");
      for (int op = 0; op < 6; op++) begin
         run_op(op, $urandom_range(2, lim[op] - 5));
         run_op(op, 0);
      end
      $display("test operations done");
      susp(0, GAP_PROG);
      susp(2, GAP_ERASE);
      $display("test suspend spacing done");
      end_of_test();
   end
endmodule : test_memory_wait_state_config
`default_nettype wire
